// file: hw/gcr_cfg.svh
`ifndef GCR_CFG_SVH
`define GCR_CFG_SVH

// register offsets
`define GCR_OFS_GIG_STATUS   5'h0A
`define GCR_OFS_EXT_CAP      5'h0F
`define GCR_OFS_PORT_CTRL    5'h10
// extra status word of live link indications
`define GCR_OFS_LIVE_STATUS  5'h11

// gigabit status fields
`define GCR_ST_FAULT_BIT     15
`define GCR_ST_MASTER_BIT    14
`define GCR_ST_LRX_BIT       13
`define GCR_ST_RRX_BIT       12
`define GCR_ST_LPFD_BIT      11
`define GCR_ST_LPHD_BIT      10

// capability word
`define GCR_EXT_CAP_VALUE    16'h3000

// port control reset value and fields
`define GCR_CTRL_RESET       16'h3060
`define GCR_CTRL_RSVD_MASK   16'h7880
`define GCR_CTRL_LP_DIS_BIT  15
`define GCR_CTRL_FLINK_BIT   10
`define GCR_CTRL_ES_HI_BIT   9
`define GCR_CTRL_ES_LO_BIT   8
`define GCR_CTRL_XO_HI_BIT   6
`define GCR_CTRL_XO_LO_BIT   5
`define GCR_CTRL_XOVER_AUTO  2'h3
`define GCR_CTRL_TX_DIS_BIT  3
`define GCR_CTRL_PD_BIT      2
`define GCR_CTRL_POL_DIS_BIT 1
`define GCR_CTRL_JAB_DIS_BIT 0

`define GCR_IDLE_MAX         8'hFF
`endif

// file: hw/gcr_pkg.sv
package gcr_pkg;
  typedef enum logic [1:0] {
    GCR_SPD_10   = 2'b00,
    GCR_SPD_100  = 2'b01,
    GCR_SPD_1000 = 2'b10
  } gcr_speed_t;

  typedef enum logic [1:0] {
    GCR_XO_STRAIGHT = 2'b00,
    GCR_XO_CROSSED  = 2'b01,
    GCR_XO_RSVD     = 2'b10,
    GCR_XO_AUTO     = 2'b11
  } gcr_xover_t;

  typedef enum logic [1:0] {
    GCR_PW_RUN  = 2'b00,
    GCR_PW_DOWN = 2'b01,
    GCR_PW_WAKE = 2'b10
  } gcr_pwr_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } gcr_bus_t;

  // events and levels from the copper core
  typedef struct packed {
    logic       ms_fault;
    logic       resolved_master;
    logic       local_rx_ok;
    logic       remote_rx_ok;
    logic       lp_gig_fd;
    logic       lp_gig_hd;
    logic       idle_error;
    gcr_speed_t speed;
    logic       full_duplex;
    logic       link_sm_up;
    logic       energy_seen;
    logic       pol_reversed;
    logic       jabber_seen;
    logic       auto_cross;
  } gcr_core_t;

  // controls to the copper core
  typedef struct packed {
    logic       link_pulse_en;
    logic       energy_sense;
    logic       energy_nlp;
    gcr_xover_t xover_mode;
    logic       tx_enable;
    logic       powered_down;
    logic       soft_reset;
    logic       restart_neg;
    logic       pol_correct_en;
    logic       jabber_en;
  } gcr_ctl_t;

  typedef struct packed {
    logic        fault;
    logic [7:0]  idle_cnt;
    logic [15:0] ctrl;
    gcr_xover_t  xover_act;
    gcr_pwr_t    pwr;
    logic        pulse;
    logic [15:0] rdata;
    logic        link_up;
    logic        pol_rev;
    logic        jabber;
  } gcr_state_t;
endpackage : gcr_pkg

// file: hw/gcr_regs.sv
`timescale 1ns/1ns
`include "gcr_cfg.svh"
module gcr_regs (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  // register port
  input  wire gcr_pkg::gcr_bus_t bus,
  output logic [15:0]          rdata,
  // software reset and main power down
  input  wire logic            sw_reset,
  input  wire logic            main_pd,
  // copper core
  input  wire gcr_pkg::gcr_core_t core,
  output gcr_pkg::gcr_ctl_t    ctl,
  output logic                 link_up,
  output logic                 pol_reversed,
  output logic                 jabber
);
  gcr_pkg::gcr_state_t s_q;
  gcr_pkg::gcr_state_t s_d;
  logic                rd_status;
  logic                pd_req;
  logic                is_10;
  logic [15:0]         status_w;
  logic [15:0]         live_w;
  logic [15:0]         ctrl_wr;
  localparam logic [15:0] ctrl_rsvd_mask = `GCR_CTRL_RSVD_MASK;

  // reserved bits keep their reset value, the rest take the write
  for (genvar b = 0; b < 16; b++) begin : g_ctrl_bit
    assign ctrl_wr[b] = ctrl_rsvd_mask[b] ? s_q.ctrl[b] : bus.wdata[b];
  end

  always_comb begin
    is_10     = (core.speed == gcr_pkg::GCR_SPD_10);
    pd_req    = main_pd | s_q.ctrl[`GCR_CTRL_PD_BIT];
    rd_status = bus.rd && (bus.addr == `GCR_OFS_GIG_STATUS);
    status_w  = 16'h0000;
    status_w[`GCR_ST_FAULT_BIT]  = s_q.fault;
    status_w[`GCR_ST_MASTER_BIT] = core.resolved_master;
    status_w[`GCR_ST_LRX_BIT]    = core.local_rx_ok;
    status_w[`GCR_ST_RRX_BIT]    = core.remote_rx_ok;
    status_w[`GCR_ST_LPFD_BIT]   = core.lp_gig_fd;
    status_w[`GCR_ST_LPHD_BIT]   = core.lp_gig_hd;
    status_w[7:0]                = s_q.idle_cnt;
    live_w = {5'h00, s_q.link_up, 3'h0,
              (s_q.xover_act == gcr_pkg::GCR_XO_CROSSED), 4'h0,
              s_q.pol_rev, s_q.jabber};
  end

  always_comb begin
    s_d       = s_q;
    s_d.pulse = 1'b0;
    // clear on read, new event wins over the clear
    if (rd_status) begin
      s_d.fault    = 1'b0;
      s_d.idle_cnt = 8'h00;
    end
    if (core.ms_fault) begin
      s_d.fault = 1'b1;
    end
    if (core.idle_error) begin
      if (rd_status) begin
        s_d.idle_cnt = 8'h01;
      end else if (s_q.idle_cnt != `GCR_IDLE_MAX) begin
        s_d.idle_cnt = s_q.idle_cnt + 8'h01;
      end
    end
    if (bus.wr && (bus.addr == `GCR_OFS_PORT_CTRL)) begin
      s_d.ctrl = ctrl_wr;
    end
    unique case (s_q.pwr)
      gcr_pkg::GCR_PW_RUN: begin
        if (pd_req) begin
          s_d.pwr = gcr_pkg::GCR_PW_DOWN;
        end
      end
      gcr_pkg::GCR_PW_DOWN: begin
        if (!pd_req) begin
          s_d.pwr = gcr_pkg::GCR_PW_WAKE;
        end
      end
      gcr_pkg::GCR_PW_WAKE: begin
        s_d.pwr   = gcr_pkg::GCR_PW_RUN;
        s_d.pulse = 1'b1;
      end
      default: begin
        s_d.pwr = gcr_pkg::GCR_PW_DOWN;
      end
    endcase
    // crossover takes the written value at software reset or at the wake pulse after power down
    if (sw_reset || s_q.pulse) begin
      s_d.xover_act = gcr_pkg::gcr_xover_t'(
        s_q.ctrl[`GCR_CTRL_XO_HI_BIT:`GCR_CTRL_XO_LO_BIT]);
    end
    s_d.link_up = core.link_sm_up
                | (s_q.ctrl[`GCR_CTRL_FLINK_BIT]
                   && core.speed != gcr_pkg::GCR_SPD_1000);
    s_d.pol_rev = core.pol_reversed
                & ~(is_10 & s_q.ctrl[`GCR_CTRL_POL_DIS_BIT]);
    s_d.jabber  = core.jabber_seen & is_10 & ~core.full_duplex
                & ~s_q.ctrl[`GCR_CTRL_JAB_DIS_BIT];
    s_d.rdata = 16'h0000;
    if (bus.rd) begin
      unique case (bus.addr)
        `GCR_OFS_GIG_STATUS:  s_d.rdata = status_w;
        `GCR_OFS_EXT_CAP:     s_d.rdata = `GCR_EXT_CAP_VALUE;
        `GCR_OFS_PORT_CTRL:   s_d.rdata = s_q.ctrl;
        `GCR_OFS_LIVE_STATUS: s_d.rdata = live_w;
        default:              s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q.fault     <= 1'b0;
      s_q.idle_cnt  <= 8'h00;
      s_q.ctrl      <= `GCR_CTRL_RESET;
      s_q.xover_act <= gcr_pkg::gcr_xover_t'(`GCR_CTRL_XOVER_AUTO);
      s_q.pwr       <= gcr_pkg::GCR_PW_RUN;
      s_q.pulse     <= 1'b0;
      s_q.rdata     <= 16'h0000;
      s_q.link_up   <= 1'b0;
      s_q.pol_rev   <= 1'b0;
      s_q.jabber    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    rdata              = s_q.rdata;
    link_up            = s_q.link_up;
    pol_reversed       = s_q.pol_rev;
    jabber             = s_q.jabber;
    ctl.link_pulse_en  = ~s_q.ctrl[`GCR_CTRL_LP_DIS_BIT];
    ctl.energy_sense   = s_q.ctrl[`GCR_CTRL_ES_HI_BIT];
    ctl.energy_nlp     = s_q.ctrl[`GCR_CTRL_ES_HI_BIT]
                       & s_q.ctrl[`GCR_CTRL_ES_LO_BIT];
    ctl.xover_mode     = s_q.xover_act;
    ctl.tx_enable      = ~s_q.ctrl[`GCR_CTRL_TX_DIS_BIT];
    ctl.powered_down   = (s_q.pwr == gcr_pkg::GCR_PW_DOWN);
    ctl.soft_reset     = s_q.pulse | sw_reset;
    ctl.restart_neg    = s_q.pulse;
    ctl.pol_correct_en = ~(is_10 & s_q.ctrl[`GCR_CTRL_POL_DIS_BIT]);
    ctl.jabber_en      = ~s_q.ctrl[`GCR_CTRL_JAB_DIS_BIT];
  end
endmodule : gcr_regs

// file: bench/gcr_checker.sv
`timescale 1ns/1ns
module gcr_checker (
  // clock and reset
  input wire logic               core_clk,
  input wire logic               reset_n,
  // register port
  input wire gcr_pkg::gcr_bus_t  bus,
  input wire logic [15:0]        rdata,
  input wire logic               sw_reset,
  input wire logic               main_pd,
  // copper core
  input wire gcr_pkg::gcr_core_t core,
  input wire gcr_pkg::gcr_ctl_t  ctl,
  input wire logic               link_up,
  input wire logic               pol_reversed,
  input wire logic               jabber
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic wc;
  assign wc = bus.wr && bus.addr == 5'h10;
  property p_cap;
    $past(bus.rd) && $past(bus.addr) == 5'h0F |-> rdata == 16'h3000;
  endproperty
  a_cap: assert property (p_cap) else $error("cap word");
  property p_lp; wc |=> ctl.link_pulse_en == !$past(bus.wdata[15]); endproperty
  a_lp: assert property (p_lp) else $error("pulse enable");
  property p_tx; wc |=> ctl.tx_enable == !$past(bus.wdata[3]); endproperty
  a_tx: assert property (p_tx) else $error("tx enable");
  property p_es;
    wc |=> ctl.energy_sense == $past(bus.wdata[9])
      && ctl.energy_nlp == &$past(bus.wdata[9:8]);
  endproperty
  a_es: assert property (p_es) else $error("energy sense");
  property p_pd; main_pd |=> ctl.powered_down; endproperty
  a_pd: assert property (p_pd) else $error("power down");
  property p_wake;
    $fell(ctl.powered_down) |-> ##[0:1] ctl.restart_neg && ctl.soft_reset;
  endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_xo; !$stable(ctl.xover_mode) |-> $past(ctl.soft_reset); endproperty
  a_xo: assert property (p_xo) else $error("xover");
  property p_link;
    $past(core.speed) == gcr_pkg::GCR_SPD_1000
      |-> link_up == $past(core.link_sm_up);
  endproperty
  a_link: assert property (p_link) else $error("gig link");
  cover property (wc);
  cover property ($fell(ctl.powered_down));
  cover property ($changed(ctl.xover_mode));
endmodule : gcr_checker

// file: bench/gcr_core_model.sv
`timescale 1ns/1ns
module gcr_core_model (
  // clock and controls
  input  wire logic               core_clk,
  input  wire gcr_pkg::gcr_ctl_t  ctl,
  // wanted and delivered core state
  input  wire gcr_pkg::gcr_core_t want,
  output gcr_pkg::gcr_core_t      core
);
  always_ff @(posedge core_clk) begin
    core <= want;
    // a dark port sees no idle errors and no link
    if (ctl.powered_down) begin
      core.idle_error <= 1'b0;
      core.link_sm_up <= 1'b0;
    end
  end
endmodule : gcr_core_model

// file: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic               core_clk = 1'b0;
  logic               reset_n = 1'b0;
  logic               sw_reset = 1'b0;
  logic               main_pd = 1'b0;
  gcr_pkg::gcr_bus_t  bus = '0;
  gcr_pkg::gcr_core_t want = '0;
  gcr_pkg::gcr_core_t core;
  gcr_pkg::gcr_ctl_t  ctl;
  logic [15:0]        rdata;
  logic [15:0]        q;
  logic               link_up;
  logic               pol_reversed;
  logic               jabber;
  int                 fail_count = 0;
  int                 checked = 0;
  int                 cyc = 0;
  always #5 core_clk = ~core_clk;
  gcr_core_model u_core (.core_clk(core_clk), .ctl(ctl), .want(want),
    .core(core));
  gcr_regs u_dut (.core_clk(core_clk), .reset_n(reset_n), .bus(bus),
    .rdata(rdata), .sw_reset(sw_reset), .main_pd(main_pd), .core(core),
    .ctl(ctl), .link_up(link_up), .pol_reversed(pol_reversed),
    .jabber(jabber));
  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic acc(input logic [4:0] a, input logic [15:0] d,
                     input logic w);
    @(posedge core_clk);
    bus <= '{a, d, w, !w};
    @(posedge core_clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    #1 q = rdata;
  endtask : acc
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic swr;
    @(posedge core_clk);
    sw_reset <= 1'b1;
    @(posedge core_clk);
    sw_reset <= 1'b0;
    #1;
  endtask : swr
  task automatic t_reset;
    logic [4:0]  a[4] = '{5'h0A, 5'h0F, 5'h10, 5'h05};
    logic [15:0] e[4] = '{16'h0000, 16'h3000, 16'h3060, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      acc(a[i], 16'h0000, 1'b0);
      chk("reset read", q, e[i]);
    end
  endtask : t_reset
  task automatic t_status;
    @(posedge core_clk);
    want <= 15'h7D00;
    repeat (3) @(posedge core_clk);
    want <= 15'h3C00;
    acc(5'h0A, 16'h0000, 1'b0);
    chk("status", q, 16'hF803);
    acc(5'h0A, 16'h0000, 1'b0);
    chk("cleared", q, 16'h7800);
    @(posedge core_clk);
    want.idle_error <= 1'b1;
    repeat (300) @(posedge core_clk);
    want.idle_error <= 1'b0;
    acc(5'h0A, 16'h0000, 1'b0);
    chk("idle sat", q, 16'h78FF);
  endtask : t_status
  task automatic t_power;
    logic saw;
    acc(5'h10, 16'hFFBF, 1'b1);
    tick(1);
    chk("ctl", 16'(ctl), 16'h03D0);
    acc(5'h10, 16'h0000, 1'b0);
    chk("ctrl keep", q, 16'hB73F);
    @(posedge core_clk);
    main_pd <= 1'b1;
    acc(5'h10, 16'h3060, 1'b1);
    tick(2);
    chk("pd main", 16'(ctl.powered_down), 16'h0001);
    @(posedge core_clk);
    main_pd <= 1'b0;
    saw = 1'b0;
    repeat (5) begin
      @(posedge core_clk);
      #1 saw |= ctl.restart_neg & ctl.soft_reset;
    end
    chk("wake", 16'(saw), 16'h0001);
  endtask : t_power
  task automatic t_link;
    @(posedge core_clk);
    want <= 15'h0006;
    acc(5'h10, 16'h3460, 1'b1);
    tick(3);
    chk("live", 16'({link_up, pol_reversed, jabber}), 16'h0007);
    acc(5'h11, 16'h0000, 1'b0);
    chk("live reg", q, 16'h0403);
    acc(5'h10, 16'h3463, 1'b1);
    tick(3);
    chk("live off", 16'({link_up, pol_reversed, jabber}), 16'h0004);
    @(posedge core_clk);
    want.speed <= gcr_pkg::GCR_SPD_1000;
    tick(3);
    chk("gig link", 16'(link_up), 16'h0000);
  endtask : t_link
  task automatic t_modes;
    logic [1:0] xo;
    logic [1:0] es;
    xo = 2'h3;
    for (int i = 0; i < 4; i++) begin
      acc(5'h10, {6'h0C, i[1:0], 1'b0, i[1:0], 5'h00}, 1'b1);
      es = {ctl.energy_sense, ctl.energy_nlp};
      chk("sense", 16'(es), 16'({i[1], &i[1:0]}));
      if (i != 3)
        chk("xover hold", 16'(ctl.xover_mode), 16'(xo));
      swr();
      if (i != 2)
        chk("xover", 16'(ctl.xover_mode), 16'(i[1:0]));
      if (i == 1) begin
        acc(5'h11, 16'h0000, 1'b0);
        chk("live xover", q, 16'h0042);
      end
      xo = i[1:0];
    end
  endtask : t_modes
  task automatic conclude;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_status();
    t_power();
    t_link();
    t_modes();
    conclude();
  end
endmodule : testbench
bind gcr_regs gcr_checker u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .bus(bus), .rdata(rdata), .sw_reset(sw_reset), .main_pd(main_pd),
  .core(core), .ctl(ctl), .link_up(link_up), .pol_reversed(pol_reversed),
  .jabber(jabber));
